/* File: inc/rslv_pkg.sv */
// rslv_pkg: constants and types for the reset sequencer with low-voltage detect
// assumes one 50 MHz system clock and a plain address/strobe register port
package rslv_pkg;
   localparam int CLK_MHZ = 50;
   localparam int WARMUP_US = 64;
   localparam int WARMUP_CYC = WARMUP_US * CLK_MHZ;
   localparam int CNT_W = 16;
   // register byte offsets
   localparam logic [7:0] ADDR_STACK_FLAGS = 8'hEF;
   localparam logic [7:0] ADDR_PSR = 8'h86;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'hF0;
   localparam logic [7:0] ADDR_IRQ_EN = 8'hF1;
   localparam logic [7:0] ADDR_IRQ_CLR = 8'hF2;
   // stack pointer / flag register fields
   localparam int BIT_GLOBAL_IRQ_EN = 7;
   localparam int BIT_FLAG_MID = 6;
   localparam int BIT_FLAG_HIGH = 5;
   localparam logic [2:0] SP_RESET = 3'h7;
   // program status reset-cause bits
   localparam int BIT_POR = 7;
   localparam int BIT_WDT = 6;
   localparam int BIT_EXT = 5;
   localparam logic [2:0] PSR_LOW_RESET = 3'h0;
   // interrupt status bits
   localparam int IRQ_MID = 0;
   localparam int IRQ_HIGH = 1;
   localparam int IRQ_N = 2;
   localparam logic [15:0] PC_START = 16'h0000;

   typedef enum logic [1:0] {
      SET_LOWEST = 2'h0,
      SET_MEDIUM = 2'h1,
      SET_HIGH = 2'h2,
      SET_MAXIMUM = 2'h3
   } rslv_setting_t;

   typedef enum logic [4:0] {
      ST_POWER = 5'h01,
      ST_PIN = 5'h02,
      ST_INIT = 5'h04,
      ST_WARM = 5'h08,
      ST_RUN = 5'h10
   } rslv_state_t;

   typedef enum logic [1:0] {
      CAUSE_POR = 2'h0,
      CAUSE_WDT = 2'h1,
      CAUSE_EXT = 2'h2
   } rslv_cause_t;
endpackage

/* File: sim/rslv_supply_model.sv */
// rslv_supply_model: supply comparators and the external reset pin
// assumes the bench moves the supply in millivolts off the clock edge
`timescale 1ns/1ps
module rslv_supply_model #(
   parameter int LOW_MV = 1800,
   parameter int MID_MV = 2400,
   parameter int HIGH_MV = 3300
) (
   input wire logic [15:0] vdd_mv,
   input wire logic pin_low,
   output logic below_low_n,
   output logic below_mid_n,
   output logic below_high_n,
   output logic supply_stable,
   output logic reset_pin_n
);
   // at-or-below trips, so a supply sitting on a level counts as low
   assign below_low_n = !(vdd_mv <= LOW_MV);
   assign below_mid_n = !(vdd_mv <= MID_MV);
   assign below_high_n = !(vdd_mv <= HIGH_MV);
   assign supply_stable = vdd_mv > LOW_MV;
   // the pin has a pull-up, so a released pin reads high
   assign reset_pin_n = !pin_low;
endmodule

/* File: sim/rslv_top_test.sv */
// rslv_top_test: self-checking bench for the reset sequencer
// assumes the supply model stands in for comparators and the pin
`timescale 1ns/1ps
module rslv_top_test;
   typedef struct {logic [1:0] set; int mv; logic [2:0] ex;} rslv_row_t;
   logic CLK = 0, RST = 1, PIN_RESET_EN = 1, WDT_OVERFLOW = 0;
   logic OSC_READY = 0, WR = 0, RD = 0, pin_low = 1;
   logic [1:0] DETECTOR_SETTING = 2'h1;
   logic [7:0] ADDR = 8'h00, WDATA = 8'h00, RDATA, d;
   logic [15:0] PC_LOAD;
   logic BELOW_LOW_N, BELOW_MID_N, BELOW_HIGH_N, SUPPLY_STABLE;
   logic RESET_PIN_N, SYS_RESET, INIT_LOAD, SLOW_MODE, IRQ;
   int vdd = 3600, errors = 0, check_count = 0, cycles = 0, n_init = 0;
   // ex is {reset, mid flag, high flag}
   rslv_row_t rows [12] = '{'{2'h0, 3000, 3'h0}, '{2'h0, 2200, 3'h0},
      '{2'h0, 1500, 3'h4}, '{2'h1, 3000, 3'h0}, '{2'h1, 2200, 3'h2},
      '{2'h1, 1500, 3'h4}, '{2'h2, 3000, 3'h1}, '{2'h2, 2200, 3'h4},
      '{2'h2, 1500, 3'h4}, '{2'h3, 3000, 3'h4}, '{2'h3, 2200, 3'h4},
      '{2'h3, 1500, 3'h4}};

   rslv_supply_model sup_u (.vdd_mv(16'(vdd)), .pin_low(pin_low),
      .below_low_n(BELOW_LOW_N), .below_mid_n(BELOW_MID_N),
      .below_high_n(BELOW_HIGH_N), .supply_stable(SUPPLY_STABLE),
      .reset_pin_n(RESET_PIN_N));
   rslv_top dut_u (.CLK(CLK), .RST(RST), .BELOW_LOW_N(BELOW_LOW_N),
      .BELOW_MID_N(BELOW_MID_N), .BELOW_HIGH_N(BELOW_HIGH_N),
      .SUPPLY_STABLE(SUPPLY_STABLE), .RESET_PIN_N(RESET_PIN_N),
      .PIN_RESET_EN(PIN_RESET_EN), .WDT_OVERFLOW(WDT_OVERFLOW),
      .OSC_READY(OSC_READY), .DETECTOR_SETTING(DETECTOR_SETTING),
      .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
      .SYS_RESET(SYS_RESET), .INIT_LOAD(INIT_LOAD), .PC_LOAD(PC_LOAD),
      .SLOW_MODE(SLOW_MODE), .IRQ(IRQ));

   always #10 CLK = ~CLK;
   always @(posedge CLK) begin
      if (INIT_LOAD === 1'b1)
         n_init = n_init + 1;
      cycles = cycles + 1;
      // about a dozen warm-ups of 3200 cycles fit well under this
      if (cycles == 60000) begin
         errors = errors + 1;
         end_of_test();
      end
   end

   task automatic chk(input string name, input logic [15:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge CLK);
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      #1 d = RDATA;
   endtask
   task automatic wr(input logic [7:0] a, v);
      @(posedge CLK);
      ADDR <= a;
      WDATA <= v;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
   endtask
   // waits out warm-up, then checks the restart state and the cause
   task automatic run(input logic [2:0] cause);
      for (int i = 0; i < 4000 && SYS_RESET !== 1'b0; i++)
         @(posedge CLK);
      chk("released", 16'(SYS_RESET), 16'h0000);
      chk("pc start", PC_LOAD, 16'h0000);
      chk("slow mode", 16'(SLOW_MODE), 16'h0000);
      rd(8'h86);
      chk("cause", 16'(d[7:5]), 16'(cause));
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial begin
      tick(6);
      RST <= 1'b0;
      tick(50);
      chk("pin hold", 16'(SYS_RESET), 16'h0001);
      chk("no init yet", 16'(n_init), 16'h0000);
      pin_low <= 1'b0;
      tick(3400);
      chk("osc wait", 16'(SYS_RESET), 16'h0001);
      chk("init once", 16'(n_init), 16'h0001);
      OSC_READY <= 1'b1;
      run(3'h4);
      rd(8'hEF);
      chk("stack reset", 16'(d), 16'h0007);
      wr(8'hEF, 8'hE5);
      rd(8'hEF);
      chk("flags ro", 16'(d), 16'h0085);
      rd(8'h00);
      chk("unmapped", 16'(d), 16'h0000);
      $display("power-up and registers done");
      n_init = 0;
      WDT_OVERFLOW <= 1'b1;
      tick(1);
      WDT_OVERFLOW <= 1'b0;
      tick(3);
      chk("wdt reset", 16'(SYS_RESET), 16'h0001);
      run(3'h2);
      chk("wdt init", 16'(n_init), 16'h0001);
      rd(8'hEF);
      chk("wdt defaults", 16'(d), 16'h0007);
      pin_low <= 1'b1;
      tick(5);
      chk("pin reset", 16'(SYS_RESET), 16'h0001);
      pin_low <= 1'b0;
      run(3'h1);
      PIN_RESET_EN <= 1'b0;
      pin_low <= 1'b1;
      tick(10);
      chk("pin off", 16'(SYS_RESET), 16'h0000);
      pin_low <= 1'b0;
      // let the released pin clear the synchroniser before re-enabling
      tick(4);
      PIN_RESET_EN <= 1'b1;
      $display("watchdog and pin done");
      wr(8'hF1, 8'h01);
      vdd <= 2200;
      tick(6);
      chk("irq set", 16'(IRQ), 16'h0001);
      rd(8'hF0);
      chk("irq stat", 16'(d[0]), 16'h0001);
      vdd <= 3600;
      wr(8'hF2, 8'h01);
      tick(2);
      chk("irq clear", 16'(IRQ), 16'h0000);
      wr(8'hF1, 8'h00);
      vdd <= 2200;
      tick(6);
      chk("irq mask", 16'(IRQ), 16'h0000);
      rd(8'hF0);
      chk("masked stat", 16'(d), 16'h0001);
      wr(8'hF2, 8'h01);
      vdd <= 3600;
      $display("interrupt done");
      foreach (rows[i]) begin
         DETECTOR_SETTING <= rows[i].set;
         tick(6);
         vdd <= rows[i].mv;
         tick(6);
         chk("lv reset", 16'(SYS_RESET), 16'(rows[i].ex[2]));
         rd(8'hEF);
         chk("lv flags", 16'(d[6:5]), 16'(rows[i].ex[1:0]));
         vdd <= 3600;
         if (rows[i].ex[2])
            run(3'h4);
         $display("setting row %0d done", i);
      end
      RST <= 1'b1;
      tick(2);
      chk("reset held", 16'(SYS_RESET), 16'h0001);
      RST <= 1'b0;
      run(3'h4);
      $display("mid-run reset done");
      end_of_test();
   end
endmodule

/* File: src/rslv_top.sv */
// rslv_top: reset sequencer, low-voltage detector decode and flag registers
// assumes comparator and pin inputs are asynchronous; watchdog shares CLK
//
// How it works
// - power-up: stable supply, pin check, init, warm-up, then run
// - with pin enabled, stay in reset while the pin is low
// - init step loads stack, irq enable, pc and mode defaults before warm-up
// - after warm-up execution starts with program counter zero
// - watchdog overflow asserts a system reset
// - watchdog sequence: check overflow, init, warm-up, run at zero
// - after watchdog reset the device restarts in normal mode
// - supply below selected threshold triggers reset
// - three detector levels; setting picks reset levels and flags
// - lowest level reset active under every setting
// - lowest setting: reset below lowest only, both flags off
// - medium: reset below lowest, mid flag only
// - high: reset below mid, high flag only
// - maximum: reset below highest level
// - mid and high flags are read-only bits 6 and 5
// - any detector reset clears both flags
// - read-only cause flags: power/brown-out, watchdog, pin
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
module rslv_top (
   input wire logic CLK,
   input wire logic RST,
   input wire logic BELOW_LOW_N,
   input wire logic BELOW_MID_N,
   input wire logic BELOW_HIGH_N,
   input wire logic SUPPLY_STABLE,
   input wire logic RESET_PIN_N,
   input wire logic PIN_RESET_EN,
   input wire logic WDT_OVERFLOW,
   input wire logic OSC_READY,
   input wire logic [1:0] DETECTOR_SETTING,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   output logic SYS_RESET,
   output logic INIT_LOAD,
   output logic [15:0] PC_LOAD,
   output logic SLOW_MODE,
   output logic IRQ
);
   // comparator outputs are active low: low means supply below that level
   typedef struct packed {
      logic [4:0] s1;
      logic [4:0] s2;
      rslv_pkg::rslv_state_t st;
      logic [rslv_pkg::CNT_W-1:0] cnt;
      logic global_irq_en;
      logic [2:0] sp;
      logic flag_mid;
      logic flag_high;
      logic [2:0] cause;
      logic [rslv_pkg::IRQ_N-1:0] ist;
      logic [rslv_pkg::IRQ_N-1:0] ien;
      logic [7:0] rdata;
      logic sys_reset;
      logic init_load;
      logic [15:0] pc;
      logic slow;
      logic irq;
   } rslv_state_s_t;

   localparam logic [rslv_pkg::CNT_W-1:0] WARM_LAST =
      (rslv_pkg::CNT_W)'(rslv_pkg::WARMUP_CYC - 1);

   rslv_state_s_t q, d;

   logic below_low, below_mid, below_high, supply_ok, pin_low;
   logic pin_en, wdt_ovf, osc_ok;
   logic det_reset, pin_reset, any_reset;
   logic mid_en, high_en;
   rslv_pkg::rslv_setting_t setting;

   // second stage only; first stage feeds nothing else
   assign below_low = ~q.s2[0];
   assign below_mid = ~q.s2[1];
   assign below_high = ~q.s2[2];
   assign supply_ok = q.s2[3];
   assign pin_low = ~q.s2[4];
   assign pin_en = PIN_RESET_EN;
   assign wdt_ovf = WDT_OVERFLOW;
   assign osc_ok = OSC_READY;
   assign setting = rslv_pkg::rslv_setting_t'(DETECTOR_SETTING);

   always_comb begin
      // lowest level always resets; high and maximum settings add levels
      det_reset = below_low;
      mid_en = 1'b0;
      high_en = 1'b0;
      case (setting)
         rslv_pkg::SET_LOWEST: begin
            mid_en = 1'b0;
         end
         rslv_pkg::SET_MEDIUM: begin
            mid_en = 1'b1;
         end
         rslv_pkg::SET_HIGH: begin
            det_reset = below_low | below_mid;
            mid_en = 1'b1;
            high_en = 1'b1;
         end
         default: begin
            det_reset = below_low | below_mid | below_high;
         end
      endcase
   end

   assign pin_reset = pin_en & pin_low;
   assign any_reset = det_reset | wdt_ovf | pin_reset;

   always_comb begin
      d = q;
      d.s1 = {RESET_PIN_N, SUPPLY_STABLE, BELOW_HIGH_N, BELOW_MID_N,
              BELOW_LOW_N};
      d.s2 = q.s1;
      d.init_load = 1'b0;
      d.rdata = 8'h00;
      d.sys_reset = 1'b1;
      case (q.st)
         rslv_pkg::ST_POWER: begin
            d.cnt = '0;
            if (supply_ok && !det_reset) begin
               d.st = rslv_pkg::ST_PIN;
            end
         end
         rslv_pkg::ST_PIN: begin
            if (det_reset || !supply_ok) begin
               d.st = rslv_pkg::ST_POWER;
            end else if (!pin_reset && !wdt_ovf) begin
               d.st = rslv_pkg::ST_INIT;
            end
         end
         rslv_pkg::ST_INIT: begin
            // defaults loaded here, before warm-up
            d.global_irq_en = 1'b0;
            d.sp = rslv_pkg::SP_RESET;
            d.ien = '0;
            d.pc = rslv_pkg::PC_START;
            d.slow = 1'b0;
            d.init_load = 1'b1;
            d.cnt = '0;
            d.st = rslv_pkg::ST_WARM;
         end
         rslv_pkg::ST_WARM: begin
            if (q.cnt != WARM_LAST) begin
               d.cnt = q.cnt + 1'b1;
            end else if (osc_ok) begin
               d.pc = rslv_pkg::PC_START;
               d.sys_reset = 1'b0;
               d.st = rslv_pkg::ST_RUN;
            end
         end
         rslv_pkg::ST_RUN: begin
            d.sys_reset = 1'b0;
         end
         default: begin
            d.st = rslv_pkg::ST_POWER;
         end
      endcase
      // a new cause aborts any step; detector or supply loss restarts from power, pin or watchdog from the check state
      if (any_reset || !supply_ok) begin
         d.sys_reset = 1'b1;
         d.st = (det_reset || !supply_ok) ? rslv_pkg::ST_POWER :
                rslv_pkg::ST_PIN;
         d.cnt = '0;
         if (det_reset || !supply_ok) begin
            d.cause = 3'b001 << rslv_pkg::CAUSE_POR;
            d.flag_mid = 1'b0;
            d.flag_high = 1'b0;
         end else if (q.st != rslv_pkg::ST_RUN) begin
            // a pin held low mid-sequence belongs to that sequence
            // so the cause that started it is kept
            d.cause = q.cause;
         end else if (wdt_ovf) begin
            d.cause = 3'b001 << rslv_pkg::CAUSE_WDT;
         end else begin
            d.cause = 3'b001 << rslv_pkg::CAUSE_EXT;
         end
      end else begin
         d.flag_mid = mid_en & below_mid;
         d.flag_high = high_en & below_high;
      end
      // sticky flag events; set wins over clear
      if (WR && ADDR == rslv_pkg::ADDR_IRQ_CLR) begin
         d.ist = q.ist & ~WDATA[rslv_pkg::IRQ_N-1:0];
      end
      if (d.flag_mid && !q.flag_mid) begin
         d.ist[rslv_pkg::IRQ_MID] = 1'b1;
      end
      if (d.flag_high && !q.flag_high) begin
         d.ist[rslv_pkg::IRQ_HIGH] = 1'b1;
      end
      if (WR && q.st == rslv_pkg::ST_RUN) begin
         if (ADDR == rslv_pkg::ADDR_STACK_FLAGS) begin
            d.global_irq_en = WDATA[rslv_pkg::BIT_GLOBAL_IRQ_EN];
            d.sp = WDATA[2:0];
         end else if (ADDR == rslv_pkg::ADDR_IRQ_EN) begin
            d.ien = WDATA[rslv_pkg::IRQ_N-1:0];
         end
      end
      if (RD) begin
         if (ADDR == rslv_pkg::ADDR_STACK_FLAGS) begin
            d.rdata[rslv_pkg::BIT_GLOBAL_IRQ_EN] = q.global_irq_en;
            d.rdata[rslv_pkg::BIT_FLAG_MID] = q.flag_mid;
            d.rdata[rslv_pkg::BIT_FLAG_HIGH] = q.flag_high;
            d.rdata[2:0] = q.sp;
         end else if (ADDR == rslv_pkg::ADDR_PSR) begin
            d.rdata[rslv_pkg::BIT_POR] = q.cause[rslv_pkg::CAUSE_POR];
            d.rdata[rslv_pkg::BIT_WDT] = q.cause[rslv_pkg::CAUSE_WDT];
            d.rdata[rslv_pkg::BIT_EXT] = q.cause[rslv_pkg::CAUSE_EXT];
         end else if (ADDR == rslv_pkg::ADDR_IRQ_STAT) begin
            d.rdata[rslv_pkg::IRQ_N-1:0] = q.ist;
         end else if (ADDR == rslv_pkg::ADDR_IRQ_EN) begin
            d.rdata[rslv_pkg::IRQ_N-1:0] = q.ien;
         end else begin
            d.rdata = 8'h00;
         end
      end
      d.irq = |(d.ist & d.ien);
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         q <= '{s1: 5'h00, s2: 5'h00, st: rslv_pkg::ST_POWER, cnt: '0,
                global_irq_en: 1'b0, sp: rslv_pkg::SP_RESET, flag_mid: 1'b0,
                flag_high: 1'b0, cause: 3'h1, ist: '0, ien: '0,
                rdata: 8'h00, sys_reset: 1'b1, init_load: 1'b0,
                pc: rslv_pkg::PC_START, slow: 1'b0, irq: 1'b0};
      end else begin
         q <= d;
      end
   end

   assign RDATA = q.rdata;
   assign SYS_RESET = q.sys_reset;
   assign INIT_LOAD = q.init_load;
   assign PC_LOAD = q.pc;
   assign SLOW_MODE = q.slow;
   assign IRQ = q.irq;

   // init followed in the next cycle by warm-up
   sequence s_init_then_warm;
      q.st == rslv_pkg::ST_INIT ##1 q.st == rslv_pkg::ST_WARM;
   endsequence

   chk_init_before_warm: assert property (
      @(posedge CLK) disable iff (RST)
      $rose(q.st == rslv_pkg::ST_WARM) |-> $past(q.st == rslv_pkg::ST_INIT))
      else $error("warm-up entered without init");

   chk_init_load_pulse: assert property (
      @(posedge CLK) disable iff (RST)
      (q.st == rslv_pkg::ST_INIT && !any_reset && supply_ok) |->
      ##1 (INIT_LOAD && q.st == rslv_pkg::ST_WARM))
      else $error("init did not pulse load");

   chk_run_at_zero: assert property (
      @(posedge CLK) disable iff (RST)
      $fell(SYS_RESET) |-> PC_LOAD == rslv_pkg::PC_START && !SLOW_MODE)
      else $error("run did not start at zero");

   chk_release_osc: assert property (
      @(posedge CLK) disable iff (RST)
      $fell(SYS_RESET) |-> $past(osc_ok) && $past(q.st == rslv_pkg::ST_WARM))
      else $error("reset released without oscillator ready");

   chk_pin_holds: assert property (
      @(posedge CLK) disable iff (RST)
      pin_reset |=> SYS_RESET)
      else $error("pin low but reset released");

   chk_wdt_reset: assert property (
      @(posedge CLK) disable iff (RST)
      wdt_ovf |=> SYS_RESET)
      else $error("watchdog overflow missed");

   chk_detector_reset: assert property (
      @(posedge CLK) disable iff (RST)
      det_reset |=> SYS_RESET && !q.flag_mid && !q.flag_high)
      else $error("detector reset missed or flags kept");

   chk_low_always: assert property (
      @(posedge CLK) disable iff (RST)
      below_low |=> q.st == rslv_pkg::ST_POWER)
      else $error("lowest level did not reset");

   chk_flags_lowest: assert property (
      @(posedge CLK) disable iff (RST)
      setting == rslv_pkg::SET_LOWEST ##1 setting == rslv_pkg::SET_LOWEST
      |-> !q.flag_mid && !q.flag_high)
      else $error("flag live under lowest setting");

   chk_seq_order: assert property (
      @(posedge CLK) disable iff (RST)
      s_init_then_warm |-> INIT_LOAD)
      else $error("init step order broken");

   chk_wdt_cause: assert property (
      @(posedge CLK) disable iff (RST)
      wdt_ovf && q.st == rslv_pkg::ST_RUN && !det_reset && supply_ok |=>
      q.cause[rslv_pkg::CAUSE_WDT] && $onehot(q.cause))
      else $error("watchdog cause not recorded");

   chk_flag_mid_level: assert property (
      @(posedge CLK) disable iff (RST)
      setting == rslv_pkg::SET_MEDIUM && below_mid && !any_reset &&
      supply_ok |=> q.flag_mid)
      else $error("mid flag not set at low supply");

   chk_flag_high_level: assert property (
      @(posedge CLK) disable iff (RST)
      setting == rslv_pkg::SET_HIGH && below_high && !any_reset &&
      supply_ok |=> q.flag_high)
      else $error("high flag not set at low supply");

   chk_high_flag_off: assert property (
      @(posedge CLK) disable iff (RST)
      setting != rslv_pkg::SET_HIGH && !pin_reset && !wdt_ovf |=>
      !q.flag_high)
      else $error("high flag live outside high setting");

   chk_max_reset: assert property (
      @(posedge CLK) disable iff (RST)
      setting == rslv_pkg::SET_MAXIMUM && below_high |=> SYS_RESET)
      else $error("maximum setting did not reset");

   chk_high_reset: assert property (
      @(posedge CLK) disable iff (RST)
      setting == rslv_pkg::SET_HIGH && below_mid |=> SYS_RESET)
      else $error("high setting did not reset");

   chk_init_defaults: assert property (
      @(posedge CLK) disable iff (RST)
      q.st == rslv_pkg::ST_INIT |=> !q.global_irq_en &&
      q.sp == rslv_pkg::SP_RESET && q.ien == '0)
      else $error("init step left a register undefined");

   chk_warm_length: assert property (
      @(posedge CLK) disable iff (RST)
      $fell(SYS_RESET) |-> $past(q.cnt) == WARM_LAST)
      else $error("warm-up cut short");

   chk_cause_onehot: assert property (
      @(posedge CLK) disable iff (RST)
      $onehot(q.cause))
      else $error("reset cause not one-hot");
endmodule
